// ### srm_pkg.sv
package srm_pkg;
	// ================================
	// Timing
	localparam int CLK_NS = 8;
	localparam int SAMPLE_NS = 128000;
	localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int SAMPLE_US = SAMPLE_NS / 1000;
	localparam int RAMP_KRPM = 1000;
	localparam int RAMP_NUM = RAMP_KRPM * SAMPLE_US / 1000;
	// ================================
	// Scaling and limits
	localparam int ANA_FS_MV = 9760;
	localparam int FREQ_DIV = 200000 * 2;
	localparam int QUAD_DIV = 500000 * 2;
	localparam int SPD_MAX = 9000;
	localparam int FS_MAX = 10000;
	localparam int FFS_MAX = 32767;
	localparam int OVS_MAX = 13000;
	localparam int GAIN_MAX = 32767;
	localparam int RAMP_MIN = 2;
	localparam int RAMP_MAX = 65535;
	localparam int TF_MIN = 1;
	localparam int TF_MAX = 1000;
	// ================================
	// Register map
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_AXIS = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_MEAS = 8'h0C;
	localparam logic [7:0] OFF_PRM = 8'h10;
	localparam logic [7:0] OFF_MODE = 8'h4C;
	localparam logic [7:0] OFF_MAIN = 8'h50;
	localparam logic [7:0] OFF_TORQ = 8'h54;
	localparam logic [31:0] CTRL_MASK = 32'h0001_3085;
	localparam logic [31:0] AXIS_MASK = 32'h0000_0021;
	localparam int CB_ANALOG = 0;
	localparam int CB_MODE = 2;
	localparam int CB_WINDOW = 7;
	localparam int CB_INT = 12;
	localparam int CB_COMP = 13;
	localparam int CB_EXT = 16;
	localparam int AB_VIRT = 0;
	localparam int AB_QUAD = 5;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;
	// Parameter word indices, byte address OFF_PRM plus four each
	localparam int P_FS1 = 0;
	localparam int P_FS2 = 1;
	localparam int P_FFS = 2;
	localparam int P_INT = 3;
	localparam int P_RAMP = 4;
	localparam int P_OVS = 9;
	localparam int P_WHI = 10;
	localparam int P_WLO = 11;
	localparam int P_KI = 12;
	localparam int P_DAMP = 13;
	localparam int P_TF = 14;
	localparam int P_NUM = 15;
	// ================================
	// Types
	typedef enum logic [2:0] {
		RAMP_ACC_POS, RAMP_DEC_POS, RAMP_ACC_NEG, RAMP_DEC_NEG, RAMP_STOP
	} srm_ramp_e;
	typedef struct packed {
		logic speed_window_flag;
		logic overspeed_flag;
	} srm_status_s;
	// ================================
	// Parameter table helpers
	function automatic int prm_lo(input int i);
		if (i == P_FS1 || i == P_FS2) return -FS_MAX;
		if (i == P_FFS) return -FFS_MAX;
		if (i == P_INT) return -SPD_MAX;
		if (i >= P_RAMP && i < P_OVS) return RAMP_MIN;
		if (i == P_WHI || i == P_WLO) return -OVS_MAX;
		if (i == P_TF) return TF_MIN;
		return 0;
	endfunction : prm_lo
	function automatic int prm_hi(input int i);
		if (i == P_FS1 || i == P_FS2) return FS_MAX;
		if (i == P_FFS) return FFS_MAX;
		if (i == P_INT) return SPD_MAX;
		if (i >= P_RAMP && i < P_OVS) return RAMP_MAX;
		if (i == P_OVS || i == P_WHI || i == P_WLO) return OVS_MAX;
		if (i == P_TF) return TF_MAX;
		return GAIN_MAX;
	endfunction : prm_hi
	function automatic logic [15:0] prm_rst(input int i);
		case (i)
			P_FS1, P_FS2, P_FFS: return 16'h0BB8;
			P_OVS: return 16'h0DAC;
			P_WHI: return 16'h0014;
			P_WLO: return 16'hFFEC;
			P_KI: return 16'h0078;
			P_DAMP: return 16'h07D0;
			P_TF: return 16'h0003;
			P_INT: return 16'h0000;
			default: return 16'h0002;
		endcase
	endfunction : prm_rst
	// Word as seen on the bus, sign-extended where negative is legal
	function automatic logic [31:0] prm_word(input int i, input logic [15:0] v);
		if (prm_lo(i) < 0) return {{16{v[15]}}, v};
		return {16'h0000, v};
	endfunction : prm_word
	function automatic int prm_index(input logic [7:0] a);
		if (a >= OFF_PRM && a < OFF_MODE && a[1:0] == 2'b00)
			return int'((a - OFF_PRM) >> 2);
		return -1;
	endfunction : prm_index
endpackage : srm_pkg

// ### srm_speed_ref.sv
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module srm_speed_ref
	import srm_pkg::*;
#(
	parameter int SAMPLE_CYCLES = SAMPLE_CYC // Clocks per control sample
)(
	input wire logic mclk, // 125 MHz clock
	input wire logic reset_n, // Asynchronous reset
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic signed [15:0] measured_motor_speed, // Speed, rpm
	input wire logic signed [15:0] mode_speed_request, // Mode request
	input wire logic signed [15:0] analog_in_mv, // Analogue input, mV
	input wire logic signed [31:0] encoder_freq_hz, // Encoder frequency
	input wire logic signed [15:0] torque_request, // Digital torque
	input wire logic stop_request, // Limit switch or stop
	output logic signed [15:0] main_reference_q, // Selected reference
	output logic signed [15:0] speed_reference_q, // Ramped reference
	output logic signed [15:0] virtual_axis_speed_q, // Virtual axis
	output logic overspeed_flag_q, // Overspeed
	output logic speed_window_flag_q, // Speed window
	output logic signed [15:0] torque_filtered_q, // Filtered torque
	output logic [15:0] integral_gain_q, // Integral gain
	output logic [15:0] proportional_gain_q, // Proportional gain
	output logic [15:0] damping_q // Damping
);
	localparam int DW = $clog2(SAMPLE_CYCLES + 1);

	// ================================
	// Reset release
	logic rst_m_q;
	logic rst_n_q;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	// ================================
	// Sample divider
	logic [DW-1:0] div_q;
	logic tick_q;
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (div_q == DW'(SAMPLE_CYCLES - 1));
			div_q <= (div_q == DW'(SAMPLE_CYCLES - 1)) ? '0 : div_q + 1'b1;
		end
	end

	// ================================
	// Bus write channel
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic wr_fire;
	logic wr_ok;
	int wi;
	assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
	assign wi = prm_index(aw_addr_q);
	assign wr_ok = aw_addr_q == OFF_CTRL || aw_addr_q == OFF_AXIS || wi >= 0;
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OK : RESP_ERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Byte-lane merge of new data into an old word
	function automatic logic [31:0] wmerge(input logic [31:0] o);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (w_strb_q[b])
				r[8*b +: 8] = w_data_q[8*b +: 8];
		return r;
	endfunction : wmerge

	// Saturate a merged word into a parameter's legal range
	function automatic logic [15:0] prm_clamp(input int i, input logic [31:0] w);
		int v;
		v = signed'(w);
		if (v < prm_lo(i))
			v = prm_lo(i);
		if (v > prm_hi(i))
			v = prm_hi(i);
		return 16'(v);
	endfunction : prm_clamp

	// ================================
	// Register file
	logic [31:0] ctrl_q;
	logic [31:0] axis_q;
	logic [15:0] prm_q [P_NUM];
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ctrl_q <= 32'h0000_0000;
			axis_q <= 32'h0000_0000;
			for (int i = 0; i < P_NUM; i++)
				prm_q[i] <= prm_rst(i);
		end else if (wr_fire) begin
			if (aw_addr_q == OFF_CTRL)
				ctrl_q <= wmerge(ctrl_q) & CTRL_MASK;
			else if (aw_addr_q == OFF_AXIS)
				axis_q <= wmerge(axis_q) & AXIS_MASK;
			else if (wi >= 0)
				prm_q[wi] <= prm_clamp(wi, wmerge(prm_word(wi, prm_q[wi])));
		end
	end

	// ================================
	// Bus read channel
	srm_status_s stat;
	logic signed [15:0] meas_q;
	logic signed [15:0] mode_q;
	logic [31:0] rd_data;
	logic rd_ok;
	int ri;
	assign stat = '{speed_window_flag: speed_window_flag_q,
		overspeed_flag: overspeed_flag_q};
	assign ri = prm_index(s_axi_araddr);
	always_comb begin
		rd_ok = 1'b1;
		rd_data = 32'h0000_0000;
		case (s_axi_araddr)
			OFF_CTRL: rd_data = ctrl_q;
			OFF_AXIS: rd_data = axis_q;
			OFF_STAT: rd_data = {30'h0, stat};
			OFF_MEAS: rd_data = 32'(meas_q);
			OFF_MODE: rd_data = 32'(mode_q);
			OFF_MAIN: rd_data = 32'(main_reference_q);
			OFF_TORQ: rd_data = 32'(torque_filtered_q);
			default: begin
				if (ri >= 0)
					rd_data = prm_word(ri, prm_q[ri]);
				else
					rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_ok ? RESP_OK : RESP_ERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ================================
	// Reference selection and ramp
	logic signed [31:0] ana_ref;
	logic signed [31:0] frq_ref;
	logic signed [31:0] src_ref;
	logic signed [31:0] main_d;
	logic signed [31:0] tgt;
	logic signed [31:0] tgt_fp;
	logic signed [31:0] ramp_q;
	logic signed [31:0] ramp_d;
	logic signed [31:0] diff;
	logic [31:0] step;
	logic [15:0] ramp_t;
	logic pos;
	logic away;
	srm_ramp_e rsel;
	always_comb begin
		ana_ref = 32'((analog_in_mv * $signed(prm_q[P_FS1])) / ANA_FS_MV);
		frq_ref = 32'((encoder_freq_hz * $signed(prm_q[P_FFS]))
			/ (axis_q[AB_QUAD] ? QUAD_DIV : FREQ_DIV));
		if (ctrl_q[CB_INT])
			src_ref = ctrl_q[CB_COMP] ? frq_ref
				: 32'($signed(prm_q[P_INT]));
		else if (!ctrl_q[CB_ANALOG])
			src_ref = ana_ref;
		else
			src_ref = frq_ref;
		main_d = (src_ref > SPD_MAX) ? SPD_MAX
			: (src_ref < -SPD_MAX) ? -SPD_MAX : src_ref;
		tgt = ctrl_q[CB_MODE] ? 32'(mode_speed_request) : main_d;
		tgt_fp = stop_request ? 32'sh0 : (tgt <<< 16);
		pos = (ramp_q > 0) || (ramp_q == 0 && tgt_fp > 0);
		away = pos ? (tgt_fp > ramp_q) : (tgt_fp < ramp_q);
		if (stop_request)
			rsel = RAMP_STOP;
		else if (!ctrl_q[CB_EXT])
			rsel = RAMP_ACC_POS;
		else if (pos)
			rsel = away ? RAMP_ACC_POS : RAMP_DEC_POS;
		else
			rsel = away ? RAMP_ACC_NEG : RAMP_DEC_NEG;
		ramp_t = prm_q[P_RAMP + int'(rsel)];
		step = (32'(RAMP_NUM) << 16) / {16'h0000, ramp_t};
		diff = tgt_fp - ramp_q;
		if (diff <= $signed(step) && diff >= -$signed(step))
			ramp_d = tgt_fp;
		else if (diff > 0)
			ramp_d = ramp_q + $signed(step);
		else
			ramp_d = ramp_q - $signed(step);
	end

	// ================================
	// Flag evaluation
	logic signed [16:0] err;
	logic signed [16:0] win_val;
	logic [16:0] abs_spd;
	logic ovs_d;
	logic win_d;
	always_comb begin
		err = 17'(measured_motor_speed) - 17'($signed(ramp_d[31:16]));
		win_val = ctrl_q[CB_WINDOW] ? 17'(measured_motor_speed) : err;
		abs_spd = measured_motor_speed[15] ? 17'(-17'(measured_motor_speed))
			: 17'(measured_motor_speed);
		ovs_d = abs_spd > {1'b0, prm_q[P_OVS]};
		win_d = win_val < 17'($signed(prm_q[P_WHI]))
			&& win_val > 17'($signed(prm_q[P_WLO]));
	end

	// ================================
	// Torque filter
	logic signed [39:0] facc_q;
	logic signed [39:0] facc_d;
	always_comb begin
		facc_d = facc_q + (({8'(torque_request[15] ? 8'hFF : 8'h00),
			torque_request, 16'h0000} - facc_q)
			/ $signed({24'h000000, prm_q[P_TF]}));
	end

	// Per-sample state update
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ramp_q <= 32'sh0;
			main_reference_q <= 16'sh0;
			speed_reference_q <= 16'sh0;
			overspeed_flag_q <= 1'b0;
			speed_window_flag_q <= 1'b0;
			meas_q <= 16'sh0;
			mode_q <= 16'sh0;
			facc_q <= 40'sh0;
			torque_filtered_q <= 16'sh0;
		end else if (tick_q) begin
			ramp_q <= ramp_d;
			main_reference_q <= 16'(main_d);
			speed_reference_q <= ramp_d[31:16];
			overspeed_flag_q <= ovs_d;
			speed_window_flag_q <= win_d;
			meas_q <= measured_motor_speed;
			mode_q <= mode_speed_request;
			facc_q <= facc_d;
			torque_filtered_q <= facc_d[31:16];
		end
	end

	// ================================
	// Gains and virtual axis
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			integral_gain_q <= 16'h0000;
			proportional_gain_q <= 16'h0000;
			damping_q <= 16'h0000;
			virtual_axis_speed_q <= 16'sh0;
		end else begin
			integral_gain_q <= prm_q[P_KI];
			damping_q <= prm_q[P_DAMP];
			proportional_gain_q <= (prm_q[P_KI] == 16'h0000)
				? prm_q[P_DAMP] : 16'h0000;
			virtual_axis_speed_q <= (axis_q[AB_VIRT] && axis_q[AB_QUAD])
				? prm_q[P_FS2] : 16'sh0;
		end
	end

	// ================================
	// Assertions
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n_q);

	flags_hold_a: assert property (!tick_q |=> $stable(overspeed_flag_q)
		&& $stable(speed_window_flag_q))
		else $error("flags moved outside a sample");
	overspeed_cmp_a: assert property (tick_q |=> overspeed_flag_q
		== ($past(abs_spd) > {1'b0, $past(prm_q[P_OVS])}))
		else $error("overspeed flag wrong");
	window_err_a: assert property (tick_q && !ctrl_q[CB_WINDOW] |=>
		speed_window_flag_q == ($past(err) < 17'($signed(prm_q[P_WHI]))
		&& $past(err) > 17'($signed(prm_q[P_WLO]))))
		else $error("error window flag wrong");
	window_spd_a: assert property (tick_q && ctrl_q[CB_WINDOW] |=>
		speed_window_flag_q == ($past(17'(measured_motor_speed))
		< 17'($signed(prm_q[P_WHI])) && $past(17'(measured_motor_speed))
		> 17'($signed(prm_q[P_WLO]))))
		else $error("speed window flag wrong");
	internal_src_a: assert property (tick_q && ctrl_q[CB_INT]
		&& !ctrl_q[CB_COMP] |=> main_reference_q == $past(prm_q[P_INT]))
		else $error("internal reference not copied");
	ramp_step_a: assert property (tick_q |=> (ramp_q - $past(ramp_q)
		<= $signed($past(step))) && ($past(ramp_q) - ramp_q
		<= $signed($past(step))))
		else $error("ramp step too large");
	stop_ramp_a: assert property (tick_q && stop_request && ramp_q >= 0
		|=> ramp_q <= $past(ramp_q) && ramp_q >= 0)
		else $error("stop ramp not toward zero");
	mode_sel_a: assert property (tick_q && ctrl_q[CB_MODE] && !stop_request
		&& 32'(mode_speed_request) == ramp_q >>> 16 && ramp_q[15:0] == 16'h0
		|=> speed_reference_q == $past(mode_speed_request))
		else $error("mode request not followed");
	prop_gain_a: assert property (prm_q[P_KI] == 16'h0000 ##1
		prm_q[P_KI] == 16'h0000 |-> proportional_gain_q == damping_q)
		else $error("damping not proportional");
	ro_write_a: assert property (wr_fire && aw_addr_q == OFF_MEAS
		|=> s_axi_bvalid && s_axi_bresp == RESP_ERR)
		else $error("read-only write not refused");
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid)
		else $error("write response dropped");

	stop_seen_c: cover property (tick_q && stop_request && ramp_q > 0);
	ovs_rise_c: cover property (!overspeed_flag_q ##1 overspeed_flag_q);
	win_rise_c: cover property (!speed_window_flag_q ##1 speed_window_flag_q);
	write_done_c: cover property (s_axi_bvalid && s_axi_bready
		&& s_axi_bresp == RESP_OK);
endmodule : srm_speed_ref

// ### speed_reference_ramp_monitor_tb.sv
`timescale 1ns/1ps
module speed_reference_ramp_monitor_tb import srm_pkg::*;;
	// ==============================
	// Stimulus and observed signals
	localparam int SC = 16;
	localparam logic [31:0] B_INT = 32'h1 << CB_INT;
	localparam logic [31:0] B_EXT = 32'h1 << CB_EXT;
	localparam logic [31:0] B_WIN = 32'h1 << CB_WINDOW;
	localparam logic [31:0] B_MODE = 32'h1 << CB_MODE;
	localparam logic [31:0] B_QUAD = 32'h1 << AB_QUAD;
	localparam logic [31:0] B_VIRT = 32'h1 << AB_VIRT;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic signed [15:0] meas = 16'h0, mreq = 16'h0, ana = 16'h0;
	logic signed [15:0] torq = 16'h0;
	logic signed [31:0] freq = 32'h0;
	logic stop = 1'b0;
	logic signed [15:0] main_q, ref_q, virt_q, tfil_q;
	logic ovs_q, win_q;
	logic [15:0] ki_q, kp_q, damp_q;
	int error_cnt = 0;
	int checked = 0;
	logic [33:0] exp_b[$];
	logic [33:0] exp_r[$];
	logic [31:0] seed = 32'h606D;
	int dflt[15] = '{3000, 3000, 3000, 0, 2, 2, 2, 2, 2, 3500, 20, -20,
		120, 2000, 3};
	int v;

	// Clock at 8 ns
	always #4 mclk = ~mclk;

	srm_speed_ref #(.SAMPLE_CYCLES(SC)) u_dut (
		.mclk(mclk), .reset_n(reset_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.measured_motor_speed(meas), .mode_speed_request(mreq),
		.analog_in_mv(ana), .encoder_freq_hz(freq),
		.torque_request(torq), .stop_request(stop),
		.main_reference_q(main_q), .speed_reference_q(ref_q),
		.virtual_axis_speed_q(virt_q), .overspeed_flag_q(ovs_q),
		.speed_window_flag_q(win_q), .torque_filtered_q(tfil_q),
		.integral_gain_q(ki_q), .proportional_gain_q(kp_q),
		.damping_q(damp_q)
	);

	// ==============================
	// Checking helpers
	task chk(input logic [33:0] seen, input logic [33:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	function automatic logic [33:0] w(input logic [15:0] x);
		return {18'h0, x};
	endfunction : w

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function automatic logic [7:0] pa(input int i);
		return OFF_PRM + 8'(4 * i);
	endfunction : pa

	task print_verdict;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict

	// Watcher: every bus answer is matched to the oldest note
	always @(posedge mclk) begin
		if (bvalid && bready && exp_b.size() > 0)
			chk({32'h0, bresp}, exp_b.pop_front());
		if (rvalid && rready && exp_r.size() > 0)
			chk({rresp, rdata}, exp_r.pop_front());
	end

	// ==============================
	// Bus master tasks
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = RESP_OK);
		bit got;
		got = 1'b0;
		exp_b.push_back({32'h0, r});
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				got = 1'b1;
				break;
			end
		end
		if (!got) error_cnt++;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = RESP_OK);
		bit got;
		got = 1'b0;
		exp_r.push_back({r, d});
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge mclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				got = 1'b1;
				break;
			end
		end
		if (!got) error_cnt++;
		rready <= 1'b0;
	endtask : rd

	// ==============================
	// Speed path helpers
	task wt(input int n);
		repeat (n * SC) @(posedge mclk);
	endtask : wt

	task automatic chg(output logic [15:0] s);
		logic [15:0] o;
		o = ref_q;
		for (int n = 0; n < 100; n++) begin
			@(negedge mclk);
			if (ref_q !== o) break;
		end
		s = ref_q;
	endtask : chg

	// Difference between two successive ramp updates
	task automatic step(input logic [15:0] e);
		logic [15:0] a, b;
		chg(a);
		chg(b);
		chk(w(b - a), w(e));
	endtask : step

	task automatic till(input logic signed [15:0] lim, input bit eq);
		bit hit;
		hit = 1'b0;
		for (int n = 0; n < 4000; n++) begin
			@(negedge mclk);
			if (eq ? ref_q === lim : ref_q < lim) begin
				hit = 1'b1;
				break;
			end
		end
		// A ramp that never arrives counts as a mismatch
		if (!hit) error_cnt++;
	endtask : till

	task automatic spd(input int s, input logic [1:0] st);
		@(posedge mclk);
		meas <= 16'(s);
		wt(2);
		rd(OFF_STAT, {30'h0, st});
		chk(w({14'h0, win_q, ovs_q}), w({14'h0, st}));
		rd(OFF_MEAS, 32'(s));
	endtask : spd

	// ==============================
	// Main sequence
	initial begin
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		for (int i = 0; i < P_NUM; i++) rd(pa(i), 32'(dflt[i]));
		rd(8'h58, 32'h0, RESP_ERR);
		rd(8'h11, 32'h0, RESP_ERR);
		wr(OFF_MEAS, 32'h5, RESP_ERR);
		// Gains saturate; zero integral hands damping to proportional
		wr(pa(P_DAMP), 32'(40000));
		rd(pa(P_DAMP), 32'h7FFF);
		@(negedge mclk);
		chk(w(kp_q), w(16'h0));
		chk(w(ki_q), w(16'(120)));
		chk(w(damp_q), w(16'h7FFF));
		wr(pa(P_KI), 32'h0);
		repeat (2) @(negedge mclk);
		chk(w(kp_q), w(16'h7FFF));
		// Torque filter range and unity setting
		wr(pa(P_TF), 32'h0);
		rd(pa(P_TF), 32'h1);
		wr(pa(P_TF), 32'(5000));
		rd(pa(P_TF), 32'(1000));
		wr(pa(P_TF), 32'h1);
		torq <= 16'(1000);
		wt(2);
		rd(OFF_TORQ, 32'(1000));
		// Analogue then frequency source
		wr(OFF_CTRL, 32'h0);
		ana <= 16'(4880);
		wt(2);
		rd(OFF_MAIN, 32'(1500));
		ana <= -16'sd9760;
		wt(2);
		rd(OFF_MAIN, 32'(-3000));
		wr(OFF_CTRL, 32'h1 << CB_ANALOG);
		freq <= 32'(200000);
		wt(2);
		rd(OFF_MAIN, 32'(1500));
		wr(OFF_AXIS, B_QUAD);
		wt(2);
		rd(OFF_MAIN, 32'(600));
		wr(pa(P_FS2), 32'(2500));
		wr(OFF_AXIS, B_QUAD | B_VIRT);
		repeat (2) @(negedge mclk);
		chk(w(virt_q), w(16'(2500)));
		// Internal reference with random values
		wr(OFF_CTRL, B_INT);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			v = int'(seed % 18001) - 9000;
			wr(pa(P_INT), 32'(v));
			wt(2);
			rd(OFF_MAIN, 32'(v));
		end
		// Four direction ramps and the stop ramp
		wr(pa(P_INT), 32'h0);
		till(0, 1);
		for (int i = 0; i < 5; i++) wr(pa(P_RAMP + i), 32'(2 << i));
		wr(OFF_CTRL, B_INT | B_EXT);
		wr(pa(P_INT), 32'(3000));
		step(16'(64));
		wr(pa(P_INT), 32'(-3000));
		step(16'(-32));
		till(0, 0);
		step(16'(-16));
		till(-200, 0);
		wr(pa(P_INT), 32'(3000));
		step(16'(8));
		@(posedge mclk);
		stop <= 1'b1;
		step(16'(4));
		till(0, 1);
		chk(w(ref_q), w(16'h0));
		@(posedge mclk);
		stop <= 1'b0;
		wr(pa(P_INT), 32'(500));
		till(500, 1);
		// Window on speed error, then overspeed
		spd(510, 2'b10);
		spd(520, 2'b00);
		spd(480, 2'b00);
		spd(481, 2'b10);
		spd(3501, 2'b01);
		spd(-3500, 2'b00);
		spd(-3501, 2'b01);
		// Window on motor speed
		wr(pa(P_WHI), 32'(600));
		wr(pa(P_WLO), 32'(400));
		wr(OFF_CTRL, B_INT | B_EXT | B_WIN);
		spd(590, 2'b10);
		spd(600, 2'b00);
		// Reduced menu: one ramp for both directions
		wr(OFF_CTRL, B_INT);
		wr(pa(P_INT), 32'(-3000));
		step(16'(-64));
		// Regulator follows the mode request
		@(posedge mclk);
		mreq <= 16'(700);
		wr(OFF_CTRL, B_INT | B_MODE);
		till(700, 1);
		chk(w(ref_q), w(16'(700)));
		rd(OFF_MODE, 32'(700));
		rd(OFF_MAIN, 32'(-3000));
		chk(w(main_q), w(16'(-3000)));
		@(posedge mclk);
		@(posedge mclk);
		print_verdict;
	end

	// Watchdog on the whole run
	initial begin
		#400000;
		error_cnt++;
		print_verdict;
	end
endmodule : speed_reference_ramp_monitor_tb
